// *** verilog/ed_dma_engine.sv ***
// Six-channel event-triggered transfer engine top level
`timescale 1ns/1ps
module ed_dma_engine
   import ed_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ED_NUM_EVT-1:0] periph_evt,
   output logic [ED_NUM_EVT-1:0] periph_evt_clr,
   input wire logic [ED_NUM_CH*ED_SEL_W-1:0] trigger_source_select,
   input wire logic [ED_NUM_CH-1:0] trigger_enable,
   input wire logic [ED_NUM_CH-1:0] trigger_software_force,
   input wire logic [ED_NUM_CH-1:0] trigger_software_clear,
   input wire logic [ED_NUM_CH-1:0] overflow_clear,
   input wire logic [ED_NUM_CH-1:0] run_start,
   input wire logic [ED_NUM_CH-1:0] run_stop,
   input wire logic [ED_NUM_CH-1:0] word_size_32,
   input wire logic [ED_NUM_CH-1:0] src_serial_rx,
   input wire logic [ED_NUM_CH-1:0] irq_at_end,
   input wire logic [ED_NUM_CH*ED_ADDR_W-1:0] src_begin_addr,
   input wire logic [ED_NUM_CH*ED_ADDR_W-1:0] dst_begin_addr,
   input wire logic [ED_NUM_CH*ED_LEN_W-1:0] burst_len_m1,
   input wire logic ch1_high_priority,
   input wire logic peripheral_frame_three_mapped,
   output logic [ED_NUM_CH-1:0] trigger_pending_flag,
   output logic [ED_NUM_CH-1:0] trigger_overflow_flag,
   output logic [ED_NUM_CH-1:0] channel_running_status,
   output logic [ED_NUM_CH-1:0] ch_irq,
   output logic [ED_ADDR_W-1:0] dma_addr,
   output logic dma_rd_en,
   input wire logic [ED_DATA_W-1:0] dma_rd_data,
   output logic dma_wr_en,
   output logic dma_wr_32,
   output logic [ED_DATA_W-1:0] dma_wr_data,
   input wire logic dma_wr_ready
);
   ed_state_t st_q;                      // Sequencer state
   logic [2:0] cur_q;                    // Channel owning the burst
   logic [2:0] rr_q;                     // Last channel served by round robin
   logic [ED_NUM_CH-1:0] run_q;          // Channel running status
   logic [ED_NUM_CH-1:0] irq_q;          // Interrupt pulses
   logic [ED_NUM_EVT-1:0] evt_clr_q;     // Clear pulses back to sources
   logic [ED_ADDR_W-1:0] src_q;          // Source pointer
   logic [ED_ADDR_W-1:0] dst_q;          // Destination pointer
   logic [ED_ADDR_W-1:0] addr_q;         // Address on the bus
   logic [ED_LEN_W-1:0] left_q;          // Words left after this one
   logic w32_q;                          // Burst uses 32-bit words
   logic srx_q;                          // Source is serial receive
   logic [ED_NUM_CH-1:0] pend;           // Pending flags
   logic [ED_NUM_CH-1:0] taken;          // Selected events this cycle
   logic [ED_NUM_CH-1:0] elig;           // Channels ready for service
   logic [ED_NUM_CH-1:0] bstart;         // Burst start per channel
   logic pick_valid;                     // Some channel may start
   logic [2:0] pick;                     // Channel chosen
   logic access_ok;                      // Address reachable now
   logic buf_in_ready;
   logic buf_out_valid;
   logic [ED_DATA_W-1:0] rd_word;        // Read data, zero if blocked
   logic push;
   logic pop;
   logic [ED_ADDR_W-1:0] step;

   // One trigger latch per channel
   for (genvar c = 0; c < ED_NUM_CH; c++)
   begin : g_ch
      ed_trig_chan u_trig
      (
         .clk(clk),
         .sys_rst(sys_rst),
         .sel(trigger_source_select[c*ED_SEL_W +: ED_SEL_W]),
         .evt_in(periph_evt),
         .sw_force(trigger_software_force[c]),
         .sw_clear(trigger_software_clear[c]),
         .ovf_clear(overflow_clear[c]),
         .burst_start(bstart[c]),
         .pending(pend[c]),
         .overflow(trigger_overflow_flag[c]),
         .evt_taken(taken[c])
      );
   end

   // Served only if latched, enabled and running
   assign elig = pend & trigger_enable & run_q;

   // Round robin, with channel 1 first when raised
   always_comb
   begin
      int j;
      j = 0;
      pick_valid = |elig;
      pick = 3'h0;
      for (int k = ED_NUM_CH; k >= 1; k--)
      begin
         j = (int'(rr_q) + k) % ED_NUM_CH;
         if (elig[j])
            pick = 3'(j);
      end
      if (ch1_high_priority && elig[0])
         pick = 3'h0;
   end

   // Burst start strobes only when idle, so bursts never overlap
   always_comb
   begin
      bstart = '0;
      if (st_q == ED_ST_IDLE && pick_valid)
         bstart[pick] = 1'b1;
   end

   // Run status
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         run_q <= '0;
      else
         run_q <= (run_q | run_start) & ~run_stop;
   end

   // Clear pulses back to every source that was taken
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         evt_clr_q <= '0;
      else
      begin
         evt_clr_q <= '0;
         for (int c = 0; c < ED_NUM_CH; c++)
            if (taken[c])
               evt_clr_q[trigger_source_select[c*ED_SEL_W +: ED_SEL_W]]
                  <= 1'b1;
      end
   end

   // Address reachability: pwm window only when mapped in frame three
   assign access_ok = !(addr_q >= ED_PWM_BASE && addr_q <= ED_PWM_LAST)
                      || peripheral_frame_three_mapped;
   assign step = w32_q ? ED_STEP32 : ED_STEP16;

   // Sequencer: gap, read address, stall, read data, write, next
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         st_q <= ED_ST_IDLE;
      else
         case (st_q)
            ED_ST_IDLE:
               if (pick_valid)
                  st_q <= ED_ST_GAP;
            ED_ST_GAP:
               st_q <= ED_ST_RADDR;
            ED_ST_RADDR:
               st_q <= srx_q ? ED_ST_RSTALL : ED_ST_RDATA;
            ED_ST_RSTALL:
               st_q <= ED_ST_RDATA;
            ED_ST_RDATA:
               if (buf_in_ready)
                  st_q <= ED_ST_WRITE;
            ED_ST_WRITE:
               if (pop)
                  st_q <= ED_ST_NEXT;
            ED_ST_NEXT:
               st_q <= (left_q == '0) ? ED_ST_IDLE : ED_ST_RADDR;
            default:
               st_q <= ED_ST_IDLE;
         endcase
   end

   // Burst setup and pointer stepping
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur_q <= 3'h0;
         rr_q <= 3'h0;
         src_q <= '0;
         dst_q <= '0;
         left_q <= '0;
         w32_q <= 1'b0;
         srx_q <= 1'b0;
      end
      else if (st_q == ED_ST_IDLE && pick_valid)
      begin
         cur_q <= pick;
         if (!(ch1_high_priority && pick == 3'h0))
            rr_q <= pick;
         src_q <= src_begin_addr[pick*ED_ADDR_W +: ED_ADDR_W];
         dst_q <= dst_begin_addr[pick*ED_ADDR_W +: ED_ADDR_W];
         left_q <= burst_len_m1[pick*ED_LEN_W +: ED_LEN_W];
         srx_q <= src_serial_rx[pick];
         // Serial transfers are held to 16-bit words
         w32_q <= word_size_32[pick] && !src_serial_rx[pick];
      end
      else if (st_q == ED_ST_NEXT)
      begin
         src_q <= src_q + step;
         dst_q <= dst_q + step;
         left_q <= left_q - 5'h01;
      end
   end

   // Bus address register: source for reads, destination for writes
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         addr_q <= '0;
      else if (st_q == ED_ST_GAP)
         addr_q <= src_q;
      else if (st_q == ED_ST_NEXT)
         addr_q <= src_q + step;
      else if (st_q == ED_ST_RDATA && buf_in_ready)
         addr_q <= dst_q;
   end

   // Read data path into the buffer; blocked reads give zero
   assign rd_word = access_ok ? dma_rd_data : '0;
   assign push = (st_q == ED_ST_RDATA);
   // Blocked writes drain without a bus strobe
   assign pop = (st_q == ED_ST_WRITE) && buf_out_valid
                && (dma_wr_ready || !access_ok);

   ed_buf2 #(.WIDTH(ED_DATA_W)) u_buf
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(push),
      .in_ready(buf_in_ready),
      .in_data(rd_word),
      .out_valid(buf_out_valid),
      .out_ready(pop),
      .out_data(dma_wr_data)
   );

   // Bus strobes
   assign dma_addr = addr_q;
   assign dma_rd_en = (st_q == ED_ST_RADDR) && access_ok;
   assign dma_wr_en = (st_q == ED_ST_WRITE) && buf_out_valid && access_ok;
   assign dma_wr_32 = w32_q;

   // Channel interrupt at burst start or at burst end
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_q <= '0;
      else
      begin
         irq_q <= '0;
         if (st_q == ED_ST_IDLE && pick_valid && !irq_at_end[pick])
            irq_q[pick] <= 1'b1;
         else if (st_q == ED_ST_NEXT && left_q == '0 && irq_at_end[cur_q])
            irq_q[cur_q] <= 1'b1;
      end
   end

   assign ch_irq = irq_q;
   assign periph_evt_clr = evt_clr_q;
   assign trigger_pending_flag = pend;
   assign channel_running_status = run_q;

   gap_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_IDLE && pick_valid |=> st_q == ED_ST_GAP
      ##1 st_q == ED_ST_RADDR) else $error("burst gap wrong");
   word4_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_RADDR && !srx_q |=> st_q == ED_ST_RDATA)
      else $error("read takes extra cycle");
   word5_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_RADDR && srx_q |=> st_q == ED_ST_RSTALL
      ##1 st_q == ED_ST_RDATA) else $error("serial read not stalled");
   start_elig_a: assert property (@(posedge clk) disable iff (sys_rst)
      |bstart |-> (bstart & elig) == bstart)
      else $error("burst on ineligible channel");
   hi_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_IDLE && ch1_high_priority && elig[0]
      |=> cur_q == 3'h0) else $error("channel 1 not preferred");
   clr_back_a: assert property (@(posedge clk) disable iff (sys_rst)
      taken[1] |=> evt_clr_q[$past(trigger_source_select[9:5])])
      else $error("no clear sent to source");
   serial16_a: assert property (@(posedge clk) disable iff (sys_rst)
      dma_wr_en && srx_q |-> !dma_wr_32) else $error("serial word 32-bit");
   irq_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      bstart[2] && !irq_at_end[2] |=> ch_irq[2])
      else $error("start interrupt missing");
   no_trig_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_IDLE && !pick_valid |=> st_q == ED_ST_IDLE)
      else $error("burst without trigger");

   burst_end_c: cover property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_NEXT && left_q == '0);
   srx_c: cover property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_RSTALL);
   wr_stall_c: cover property (@(posedge clk) disable iff (sys_rst)
      dma_wr_en && !dma_wr_ready);
   hi_prio_c: cover property (@(posedge clk) disable iff (sys_rst)
      st_q == ED_ST_IDLE && ch1_high_priority && elig[0] && elig[3]);
endmodule

// *** verilog/ed_pkg.sv ***
// Shared constants and types for the six-channel event-driven transfer engine
package ed_pkg;
   localparam int ED_NUM_CH = 6;          // Transfer channels
   localparam int ED_SEL_W = 5;           // Trigger source select width
   localparam int ED_NUM_EVT = 30;        // Event inputs, index 0 unused
   localparam int ED_ADDR_W = 22;         // Engine bus address width
   localparam int ED_DATA_W = 32;         // Engine bus data width
   localparam int ED_LEN_W = 5;           // Burst length field width
   localparam int ED_CYC_WORD = 4;        // Cycles per word
   localparam int ED_CYC_WORD_SRX = 5;    // Cycles per word, serial receive
   localparam int ED_BURST_GAP = 1;       // Idle cycles ahead of a burst
   localparam int ED_BUF_DEPTH = 2;       // Data path buffer entries
   // Event source numbering
   localparam logic [4:0] ED_EVT_SW_ONLY = 5'h00;  // Software force only
   localparam logic [4:0] ED_EVT_SEQ1 = 5'h01;     // Converter sequencer 1
   localparam logic [4:0] ED_EVT_SEQ2 = 5'h02;     // Converter sequencer 2
   localparam logic [4:0] ED_EVT_XINT1 = 5'h03;    // Ext int 1..7 at 3..9
   localparam logic [4:0] ED_EVT_XINT13 = 5'h0a;   // External interrupt 13
   localparam logic [4:0] ED_EVT_TMR0 = 5'h0b;     // Timers 0..2 at 11..13
   localparam logic [4:0] ED_EVT_SER_A_TX = 5'h0e; // A tx, A rx, B tx, B rx
   localparam logic [4:0] ED_EVT_PWM1_A = 5'h12;   // Pwm n a/b at 18..29
   // Window of the pulse width modulator registers in frame three
   localparam logic [21:0] ED_PWM_BASE = 22'h006800;
   localparam logic [21:0] ED_PWM_LAST = 22'h006fff;
   localparam logic [21:0] ED_STEP16 = 22'h000001; // Address step, 16-bit
   localparam logic [21:0] ED_STEP32 = 22'h000002; // Address step, 32-bit
   // Transfer sequencer states
   typedef enum logic [2:0]
   {
      ED_ST_IDLE,
      ED_ST_GAP,
      ED_ST_RADDR,
      ED_ST_RSTALL,
      ED_ST_RDATA,
      ED_ST_WRITE,
      ED_ST_NEXT
   } ed_state_t;
endpackage

// *** verilog/ed_buf2.sv ***
// Two-entry data buffer with valid and ready on both sides
`timescale 1ns/1ps
module ed_buf2
#(
   parameter int WIDTH = 32
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot_q [2];  // Storage slots
   logic wp_q;                    // Write slot
   logic rp_q;                    // Read slot
   logic [1:0] cnt_q;             // Words held
   logic push;
   logic pop;

   // Handshakes and data out of the slot register
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = slot_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Slot storage
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         slot_q[0] <= '0;
         slot_q[1] <= '0;
      end
      else if (push)
         slot_q[wp_q] <= in_data;
   end

   // Pointers and fill count
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
            wp_q <= ~wp_q;
         if (pop)
            rp_q <= ~rp_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end

   // Never more than two words held
   buf_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
      cnt_q <= 2'h2) else $error("buffer count above two");
endmodule

// *** verilog/ed_trig_chan.sv ***
// Per-channel trigger latch with pending and overflow flags
`timescale 1ns/1ps
module ed_trig_chan
   import ed_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ED_SEL_W-1:0] sel,
   input wire logic [ED_NUM_EVT-1:0] evt_in,
   input wire logic sw_force,
   input wire logic sw_clear,
   input wire logic ovf_clear,
   input wire logic burst_start,
   output logic pending,
   output logic overflow,
   output logic evt_taken
);
   logic pend_q;   // Trigger pending flag
   logic ovf_q;    // Trigger overflow flag
   logic trig;     // Any trigger this cycle

   // Selected source; code 0 and unused codes pick no event
   always_comb
   begin
      evt_taken = 1'b0;
      if (sel != ED_EVT_SW_ONLY && 32'(sel) < ED_NUM_EVT)
         evt_taken = evt_in[sel];
   end

   // Force works whatever the select holds
   assign trig = evt_taken || sw_force;

   // Pending flag: set beats any clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pend_q <= 1'b0;
      else if (trig)
         pend_q <= 1'b1;
      else if (burst_start || sw_clear)
         pend_q <= 1'b0;
   end

   // Overflow: trigger while one already waits unserved
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         ovf_q <= 1'b0;
      else if (trig && pend_q && !burst_start)
         ovf_q <= 1'b1;
      else if (ovf_clear)
         ovf_q <= 1'b0;
   end

   assign pending = pend_q;
   assign overflow = ovf_q;

   pend_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig |=> pend_q) else $error("trigger not latched");
   pend_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      burst_start && !trig |=> !pend_q) else $error("pending not cleared");
   sw_clr_a: assert property (@(posedge clk) disable iff (sys_rst)
      sw_clear && !trig |=> !pend_q) else $error("soft clear ignored");
   ovf_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      trig && pend_q && !burst_start |=> ovf_q)
      else $error("overflow not flagged");
   ovf_cov_c: cover property (@(posedge clk) disable iff (sys_rst)
      trig && pend_q && !burst_start);
endmodule

// *** sim/ed_bus_model.sv ***
// Bus partner model: memories and peripherals on the engine bus
`timescale 1ns/1ps
module ed_bus_model
   import ed_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic stall_en,
   input wire logic [ED_ADDR_W-1:0] dma_addr,
   input wire logic dma_rd_en,
   output logic [ED_DATA_W-1:0] dma_rd_data,
   input wire logic dma_wr_en,
   output logic dma_wr_ready
);
   logic [ED_DATA_W-1:0] rd_q; // Word being returned
   logic [1:0] hold_q; // Cycles the word stays on the bus

   // Read answer one cycle after the strobe, held two cycles
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rd_q <= '0;
         hold_q <= 2'h0;
      end
      else if (dma_rd_en)
      begin
         rd_q <= {~dma_addr[15:0], dma_addr[15:0]};
         hold_q <= 2'h2;
      end
      else if (hold_q != 2'h0)
         hold_q <= hold_q - 2'h1;
   end

   // Released read bus shows the inverse, never the old word
   assign dma_rd_data = (hold_q != 2'h0) ? rd_q : ~rd_q;

   // Write ready, stalling at random when asked
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         dma_wr_ready <= 1'b0;
      else
         dma_wr_ready <= !stall_en || ($urandom_range(1) == 1);
   end
endmodule

// *** sim/ed_dma_engine_tb.sv ***
// Self-checking bench for the event-triggered transfer engine
`timescale 1ns/1ps
module ed_dma_engine_tb
   import ed_pkg::*;
;
   logic clk, sys_rst, stall_en, ch1_high_priority;
   logic peripheral_frame_three_mapped, dma_rd_en, dma_wr_en;
   logic dma_wr_32, dma_wr_ready;
   logic [29:0] periph_evt, periph_evt_clr, trigger_source_select;
   logic [29:0] burst_len_m1;
   logic [5:0] trigger_enable, trigger_software_force;
   logic [5:0] trigger_software_clear, overflow_clear, run_start;
   logic [5:0] run_stop, word_size_32, src_serial_rx, irq_at_end;
   logic [5:0] trigger_pending_flag, trigger_overflow_flag;
   logic [5:0] channel_running_status, ch_irq;
   logic [131:0] src_begin_addr, dst_begin_addr;
   logic [21:0] dma_addr;
   logic [31:0] dma_rd_data, dma_wr_data, m;
   logic [54:0] exq[$]; // Expected writes: wide, address, data
   logic [54:0] e;
   int rdt[$]; // Cycles of read strobes
   int cyc, irqt, error_cnt, compares;
   logic [5:0] irqv; // Last interrupt vector seen
   int c, n;
   bit w;
   logic [21:0] sa, da;

   ed_dma_engine dut (.clk, .sys_rst, .periph_evt, .periph_evt_clr,
      .trigger_source_select, .trigger_enable, .trigger_software_force,
      .trigger_software_clear, .overflow_clear, .run_start, .run_stop,
      .word_size_32, .src_serial_rx, .irq_at_end, .src_begin_addr,
      .dst_begin_addr, .burst_len_m1, .ch1_high_priority,
      .peripheral_frame_three_mapped, .trigger_pending_flag,
      .trigger_overflow_flag, .channel_running_status, .ch_irq, .dma_addr,
      .dma_rd_en, .dma_rd_data, .dma_wr_en, .dma_wr_32, .dma_wr_data,
      .dma_wr_ready);

   ed_bus_model partner (.clk, .sys_rst, .stall_en, .dma_addr, .dma_rd_en,
      .dma_rd_data, .dma_wr_en, .dma_wr_ready);

   // Clock, 8 ns period
   always #4 clk = ~clk;

   // Compare one value with its expectation
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Load a channel and note the writes its burst should make
   task automatic plan(int ch, int len, bit wd, bit sx, logic [21:0] s0,
                       logic [21:0] d0, bit want);
      logic [21:0] st;
      logic [21:0] a;
      st = (wd && !sx) ? ED_STEP32 : ED_STEP16;
      word_size_32[ch] <= wd;
      src_serial_rx[ch] <= sx;
      src_begin_addr[ch*ED_ADDR_W +: ED_ADDR_W] <= s0;
      dst_begin_addr[ch*ED_ADDR_W +: ED_ADDR_W] <= d0;
      burst_len_m1[ch*ED_LEN_W +: ED_LEN_W] <= 5'(len - 1);
      for (int k = 0; k < len; k++)
      begin
         a = s0 + 22'(k) * st;
         if (want)
            exq.push_back({wd && !sx, d0 + 22'(k) * st, ~a[15:0], a[15:0]});
      end
   endtask

   // One-cycle software force on a channel
   task automatic trig(int ch);
      trigger_software_force[ch] <= 1'b1;
      @(posedge clk);
      trigger_software_force[ch] <= 1'b0;
   endtask

   // Wait, bounded, until every noted write has been seen
   task automatic drain();
      int t;
      t = 0;
      while (exq.size() != 0 && t < 3000)
      begin
         @(posedge clk);
         t++;
      end
      chk(exq.size(), 0);
      repeat (8) @(posedge clk);
   endtask

   // Monitor: strobes, interrupts and accepted writes
   always @(posedge clk)
   begin
      cyc++;
      if (dma_rd_en === 1'b1)
         rdt.push_back(cyc);
      if (ch_irq !== 6'h00)
      begin
         irqt = cyc;
         irqv = ch_irq;
      end
      if (dma_wr_en === 1'b1 && dma_wr_ready === 1'b1)
      begin
         if (exq.size() == 0)
            chk(1, 0);
         else
         begin
            e = exq.pop_front();
            m = e[54] ? 32'hffffffff : 32'h0000ffff;
            chk(dma_wr_32, e[54]);
            chk(dma_addr, e[53:32]);
            chk(dma_wr_data & m, e[31:0] & m);
         end
      end
   end

   // Watchdog against a hang
   initial
   begin
      #200000;
      error_cnt++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      {clk, stall_en, ch1_high_priority, peripheral_frame_three_mapped} = '0;
      {periph_evt, trigger_source_select, burst_len_m1, trigger_enable} = '0;
      {trigger_software_force, trigger_software_clear, overflow_clear} = '0;
      {run_start, run_stop, word_size_32, src_serial_rx, irq_at_end} = '0;
      {src_begin_addr, dst_begin_addr, cyc, irqt, error_cnt, compares} = '0;
      irqv = '0;
      sys_rst = 1'b1;
      void'($urandom(89));
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1 chk({trigger_pending_flag, trigger_overflow_flag,
              channel_running_status}, 0);
      // Software-only select and an unused code ignore every event line
      @(posedge clk);
      trigger_source_select[29:25] <= 5'h1f;
      periph_evt <= '1;
      @(posedge clk);
      periph_evt <= '0;
      #1 chk(trigger_pending_flag, 0);
      // Every source code latches on its own channel only
      for (int s = 1; s < ED_NUM_EVT; s++)
      begin
         c = s % ED_NUM_CH;
         @(posedge clk);
         trigger_source_select[c*ED_SEL_W +: ED_SEL_W] <= 5'(s);
         @(posedge clk);
         periph_evt[s] <= 1'b1;
         @(posedge clk);
         periph_evt[s] <= 1'b0;
         #1 chk(trigger_pending_flag, 6'h01 << c);
         chk(periph_evt_clr, 30'h1 << s);
         @(posedge clk);
         trigger_software_clear[c] <= 1'b1;
         @(posedge clk);
         trigger_software_clear[c] <= 1'b0;
         #1 chk(trigger_pending_flag, 0);
      end
      // Second trigger before service raises overflow
      @(posedge clk);
      trigger_software_force[2] <= 1'b1;
      repeat (2) @(posedge clk);
      trigger_software_force[2] <= 1'b0;
      #1 chk(trigger_overflow_flag, 6'h04);
      @(posedge clk);
      overflow_clear[2] <= 1'b1;
      @(posedge clk);
      overflow_clear[2] <= 1'b0;
      #1 chk(trigger_overflow_flag, 0);
      // Trigger in the same cycle as a clear keeps pending
      @(posedge clk);
      {trigger_software_clear[2], trigger_software_force[2]} <= 2'h3;
      @(posedge clk);
      {trigger_software_force[2], overflow_clear[2]} <= 2'h1;
      #1 chk(trigger_pending_flag, 6'h04);
      @(posedge clk);
      {trigger_software_clear[2], overflow_clear[2]} <= 2'h0;
      #1 chk({trigger_pending_flag, trigger_overflow_flag}, 0);
      // Enable and start all channels
      trigger_enable <= 6'h3f;
      run_start <= 6'h3f;
      @(posedge clk);
      run_start <= 6'h00;
      #1 chk(channel_running_status, 6'h3f);
      // Word pacing and gap, plain source then serial receive
      for (int sx = 0; sx < 2; sx++)
      begin
         @(posedge clk);
         rdt.delete();
         plan(1, 3, 1, sx, 22'h000100, 22'h002000, 1);
         trig(1);
         drain();
         chk(irqv, 6'h02);
         chk(rdt.size(), 3);
         if (rdt.size() == 3)
         begin
            chk(rdt[0] - irqt, ED_BURST_GAP);
            chk(rdt[2] - rdt[1], sx ? ED_CYC_WORD_SRX : ED_CYC_WORD);
            chk(rdt[1] - rdt[0], sx ? ED_CYC_WORD_SRX : ED_CYC_WORD);
         end
      end
      // Random bursts under write stalls, retrigger mid-burst
      stall_en <= 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         c = $urandom_range(5);
         n = $urandom_range(8, 1);
         w = $urandom_range(1);
         sa = 22'($urandom_range(16'h3fff));
         da = 22'($urandom_range(16'h3fff));
         irq_at_end[c] <= $urandom_range(1);
         ch1_high_priority <= $urandom_range(1);
         plan(c, n, w, 0, sa, da, 1);
         trig(c);
         if (i % 2 == 1)
         begin
            repeat (2) @(posedge clk);
            plan(c, n, w, 0, sa, da, 1);
            trig(c);
         end
         drain();
      end
      // Pwm window refused until frame three is mapped
      stall_en <= 1'b0;
      plan(0, 2, 0, 0, 22'h000010, ED_PWM_BASE, 0);
      trig(0);
      repeat (30) @(posedge clk);
      peripheral_frame_three_mapped <= 1'b1;
      plan(0, 2, 0, 0, 22'h000010, ED_PWM_BASE, 1);
      trig(0);
      drain();
      // Stopped channel holds its trigger until started
      run_stop[3] <= 1'b1;
      @(posedge clk);
      run_stop[3] <= 1'b0;
      plan(3, 2, 1, 0, 22'h000040, 22'h001000, 1);
      trig(3);
      repeat (20) @(posedge clk);
      #1 chk(trigger_pending_flag[3], 1);
      chk(exq.size(), 2);
      @(posedge clk);
      run_start[3] <= 1'b1;
      @(posedge clk);
      run_start[3] <= 1'b0;
      drain();
      #1 chk(trigger_pending_flag[3], 0);
      // Channel 1 served before a round-robin rival raised with it
      ch1_high_priority <= 1'b1;
      plan(0, 2, 0, 0, 22'h000200, 22'h003000, 1);
      plan(5, 2, 0, 0, 22'h000300, 22'h003100, 1);
      @(posedge clk);
      trigger_software_force <= 6'h21;
      @(posedge clk);
      trigger_software_force <= 6'h00;
      drain();
      complete_run();
   end
endmodule
